/* core/mdifd_decoder.sv */
// What this block does
// - Forced stop input stops drive with a stop pulse; a fresh run command is needed.
// - Parameter lock input rejects all parameter writes.
// - Loop regulator disable input holds closed-loop regulation off.
// - Jog direction: ON reverse, OFF forward, updated only while jogging.
// - Normally-closed reset behaves as normally-open reset with opened contact.
// - Frequency source select: ON second source, OFF first.
// - Operation source select: ON second run/stop source, OFF first.
// - One-shot sequencer start latches on a pulse; stop cancels it.
// - Output shutoff lets motor coast; its release restarts from zero.
// - Both analog selects on: voltage, then current, then bipolar.
// - Step inputs form binary index 1,2,4,8; zero picks master frequency.
// - Every input is delayed 1 to 20 units of 2 ms.
// - Index stop keeps running after stop until proximity, then decelerates.
// - Gear 4..1000 default 200, angle 0..3600 default 1800, decel 0..10000.
// - Fifteen step frequencies, 0 to 40000 hundredths of Hz, default 0.
// - Sequencer mode 00 off, 01 one cycle, 02 continuous.
// - Reset input clears the fault once the fault condition has gone.
// - Functions 01 to 04 are the step select inputs.
// - Level-run sequencer function runs the program while active.
`timescale 1ns/1ps
module mdifd_decoder #(
   parameter int N_TERM = mdifd_pkg::N_TERM,
   parameter int DEB_UNIT_CYC = mdifd_pkg::DEB_UNIT_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [N_TERM-1:0] term_contact_in,
   input wire logic [N_TERM-1:0][5:0] term_func_in,
   input wire logic jog_active_in,
   input wire logic run1_in,
   input wire logic stop1_in,
   input wire logic run2_in,
   input wire logic stop2_in,
   input wire logic fault_present_in,
   input wire logic [15:0] master_freq_in,
   input wire logic param_wr_in,
   input wire logic [4:0] param_addr_in,
   input wire logic [15:0] param_data_in,
   output logic param_ack_out,
   output logic param_err_out,
   output logic param_lock_out,
   output logic run_out,
   output logic stop_pulse_out,
   output logic index_wait_out,
   output logic index_decel_out,
   output logic output_off_out,
   output logic restart_zero_out,
   output logic fault_clear_out,
   output logic loop_regulator_off_out,
   output logic jog_rev_out,
   output logic freq_src2_out,
   output logic op_src2_out,
   output mdifd_pkg::mdifd_asel_t analog_sel_out,
   output logic [3:0] step_idx_out,
   output logic [15:0] step_freq_out,
   output logic step_sequencer_run_out,
   output logic step_sequencer_start_out,
   output mdifd_pkg::mdifd_seq_mode_t seq_mode_out,
   output mdifd_pkg::mdifd_index_cfg_t index_cfg_out,
   output logic [N_TERM-1:0] term_level_out
);
   // ----------------------------------------
   // Input synchronisers and debounce
   // ----------------------------------------
   logic [N_TERM-1:0] sync1_ff;
   logic [N_TERM-1:0] sync2_ff;
   logic [N_TERM-1:0] stable_ff;
   logic [18:0] unit_cnt_ff;
   logic unit_tick_ff;
   logic [4:0] deb_units_ff;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= term_contact_in;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         unit_cnt_ff <= '0;
         unit_tick_ff <= 1'b0;
      end
      else if (unit_cnt_ff == 19'(DEB_UNIT_CYC - 1))
      begin
         unit_cnt_ff <= '0;
         unit_tick_ff <= 1'b1;
      end
      else
      begin
         unit_cnt_ff <= unit_cnt_ff + 19'h00001;
         unit_tick_ff <= 1'b0;
      end
   end

   for (genvar g = 0; g < N_TERM; g++)
   begin : g_deb
      logic [4:0] held_ff;
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
         begin
            held_ff <= '0;
            stable_ff[g] <= 1'b0;
         end
         else if (sync2_ff[g] == stable_ff[g])
         begin
            held_ff <= '0;
         end
         else if (unit_tick_ff)
         begin
            if (held_ff + 5'h01 >= deb_units_ff)
            begin
               held_ff <= '0;
               stable_ff[g] <= sync2_ff[g];
            end
            else
            begin
               held_ff <= held_ff + 5'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Function decode
   // ----------------------------------------
   // Any terminal set to code and active at its contact sense
   function automatic logic term_act(input logic [5:0] code, input logic nc);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERM; i++)
      begin
         if (term_func_in[i] == code)
         begin
            hit = hit | (nc ? ~stable_ff[i] : stable_ff[i]);
         end
      end
      return hit;
   endfunction

   function automatic logic term_has(input logic [5:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERM; i++)
      begin
         hit = hit | (term_func_in[i] == code);
      end
      return hit;
   endfunction

   mdifd_pkg::mdifd_act_t act;
   logic index_en;

   always_comb
   begin
      act.forced_stop = term_act(mdifd_pkg::F_FSTOP_NO, 1'b0) |
                        term_act(mdifd_pkg::F_FSTOP_NC, 1'b1);
      act.param_lock = term_act(mdifd_pkg::F_PLOCK, 1'b0);
      act.loop_off = term_act(mdifd_pkg::F_LOOP_OFF, 1'b0);
      act.jog_dir = term_act(mdifd_pkg::F_JOG_DIR, 1'b0);
      act.fault_reset = term_act(mdifd_pkg::F_RST_NO, 1'b0) |
                        term_act(mdifd_pkg::F_RST_NC, 1'b1);
      act.fsrc2 = term_act(mdifd_pkg::F_FSRC2, 1'b0);
      act.opsrc2 = term_act(mdifd_pkg::F_OPSRC2, 1'b0);
      act.seq_level = term_act(mdifd_pkg::F_SEQ_RUN, 1'b0);
      act.seq_shot = term_act(mdifd_pkg::F_SEQ_SHOT, 1'b0);
      act.prox = term_act(mdifd_pkg::F_PROX, 1'b0);
      act.shutoff = term_act(mdifd_pkg::F_SHUT_NO, 1'b0) |
                    term_act(mdifd_pkg::F_SHUT_NC, 1'b1);
      act.asel_cur = term_act(mdifd_pkg::F_ASEL_CUR, 1'b0);
      act.asel_bip = term_act(mdifd_pkg::F_ASEL_BIP, 1'b0);
      act.step_idx = {term_act(mdifd_pkg::F_STEP4, 1'b0),
                      term_act(mdifd_pkg::F_STEP3, 1'b0),
                      term_act(mdifd_pkg::F_STEP2, 1'b0),
                      term_act(mdifd_pkg::F_STEP1, 1'b0)};
      index_en = term_has(mdifd_pkg::F_PROX);
   end

   mdifd_pkg::mdifd_act_t act_q_ff;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         act_q_ff <= '0;
      end
      else
      begin
         act_q_ff <= act;
      end
   end

   // ----------------------------------------
   // Parameter store
   // ----------------------------------------
   logic wr_ok;
   logic step_wr;
   logic [15:0] step_rd;

   always_comb
   begin
      unique case (param_addr_in)
         mdifd_pkg::PA_GEAR: wr_ok = (param_data_in >= mdifd_pkg::GEAR_MIN) &&
                                     (param_data_in <= mdifd_pkg::GEAR_MAX);
         mdifd_pkg::PA_ANGLE: wr_ok = param_data_in <= mdifd_pkg::ANGLE_MAX;
         mdifd_pkg::PA_DECEL: wr_ok = param_data_in <= mdifd_pkg::DECEL_MAX;
         mdifd_pkg::PA_SEQ_MODE: wr_ok = param_data_in <= 16'(mdifd_pkg::SEQ_LOOP);
         mdifd_pkg::PA_DEB: wr_ok = (param_data_in >= 16'(mdifd_pkg::DEB_MIN)) &&
                                    (param_data_in <= 16'(mdifd_pkg::DEB_MAX));
         default: wr_ok = (param_addr_in <= mdifd_pkg::PA_STEP_LAST) &&
                          (param_data_in <= mdifd_pkg::STEP_MAX);
      endcase
      wr_ok = wr_ok & ~act.param_lock;
   end

   assign step_wr = param_wr_in & wr_ok & (param_addr_in <= mdifd_pkg::PA_STEP_LAST);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         param_ack_out <= 1'b0;
         param_err_out <= 1'b0;
      end
      else
      begin
         param_ack_out <= param_wr_in & wr_ok;
         param_err_out <= param_wr_in & ~wr_ok;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         index_cfg_out.gear <= mdifd_pkg::GEAR_RST;
         index_cfg_out.angle <= mdifd_pkg::ANGLE_RST;
         index_cfg_out.decel <= mdifd_pkg::DECEL_RST;
         seq_mode_out <= mdifd_pkg::SEQ_OFF;
         deb_units_ff <= mdifd_pkg::DEB_RST;
      end
      else if (param_wr_in && wr_ok)
      begin
         unique case (param_addr_in)
            mdifd_pkg::PA_GEAR: index_cfg_out.gear <= param_data_in;
            mdifd_pkg::PA_ANGLE: index_cfg_out.angle <= param_data_in;
            mdifd_pkg::PA_DECEL: index_cfg_out.decel <= param_data_in;
            mdifd_pkg::PA_SEQ_MODE:
               seq_mode_out <= mdifd_pkg::mdifd_seq_mode_t'(param_data_in[1:0]);
            mdifd_pkg::PA_DEB: deb_units_ff <= param_data_in[4:0];
            default: deb_units_ff <= deb_units_ff;
         endcase
      end
   end

   mdifd_step_mem #(
      .DEPTH(mdifd_pkg::N_STEP),
      .WIDTH(mdifd_pkg::FREQ_W),
      .AW(4)
   ) u_step_mem (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(step_wr),
      .wr_addr_in(param_addr_in[3:0]),
      .wr_data_in(param_data_in),
      .rd_addr_in(act.step_idx - 4'h1),
      .rd_data_out(step_rd)
   );

   // ----------------------------------------
   // Step frequency select
   // ----------------------------------------
   logic [3:0] idx_d_ff;
   logic [15:0] master_d_ff;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         idx_d_ff <= '0;
         master_d_ff <= '0;
         step_idx_out <= '0;
         step_freq_out <= '0;
      end
      else
      begin
         idx_d_ff <= act.step_idx;
         master_d_ff <= master_freq_in;
         step_idx_out <= idx_d_ff;
         step_freq_out <= (idx_d_ff == 4'h0) ? master_d_ff : step_rd;
      end
   end

   // ----------------------------------------
   // Run control and index stop
   // ----------------------------------------
   mdifd_pkg::mdifd_run_st_t run_st_ff;
   logic run_req;
   logic stop_req;

   assign run_req = act.opsrc2 ? run2_in : run1_in;
   assign stop_req = act.opsrc2 ? stop2_in : stop1_in;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_st_ff <= mdifd_pkg::ST_STOPPED;
         stop_pulse_out <= 1'b0;
         index_decel_out <= 1'b0;
      end
      else
      begin
         stop_pulse_out <= 1'b0;
         index_decel_out <= 1'b0;
         unique case (run_st_ff)
            mdifd_pkg::ST_STOPPED:
               if (run_req && !act.forced_stop)
               begin
                  run_st_ff <= mdifd_pkg::ST_RUNNING;
               end
            mdifd_pkg::ST_RUNNING:
               if (act.forced_stop)
               begin
                  run_st_ff <= mdifd_pkg::ST_STOPPED;
                  stop_pulse_out <= 1'b1;
               end
               else if (stop_req && index_en)
               begin
                  run_st_ff <= mdifd_pkg::ST_INDEX_WAIT;
               end
               else if (stop_req)
               begin
                  run_st_ff <= mdifd_pkg::ST_STOPPED;
                  stop_pulse_out <= 1'b1;
               end
            mdifd_pkg::ST_INDEX_WAIT:
               if (act.forced_stop)
               begin
                  run_st_ff <= mdifd_pkg::ST_STOPPED;
                  stop_pulse_out <= 1'b1;
               end
               else if (act.prox && !act_q_ff.prox)
               begin
                  run_st_ff <= mdifd_pkg::ST_STOPPED;
                  index_decel_out <= 1'b1;
               end
            default:
               run_st_ff <= mdifd_pkg::ST_STOPPED;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_out <= 1'b0;
         index_wait_out <= 1'b0;
      end
      else
      begin
         run_out <= run_st_ff != mdifd_pkg::ST_STOPPED;
         index_wait_out <= run_st_ff == mdifd_pkg::ST_INDEX_WAIT;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         output_off_out <= 1'b0;
         restart_zero_out <= 1'b0;
      end
      else
      begin
         output_off_out <= act.shutoff;
         restart_zero_out <= act_q_ff.shutoff & ~act.shutoff;
      end
   end

   // ----------------------------------------
   // Fault reset
   // ----------------------------------------
   logic reset_pend_ff;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reset_pend_ff <= 1'b0;
         fault_clear_out <= 1'b0;
      end
      else
      begin
         fault_clear_out <= 1'b0;
         if (reset_pend_ff && !fault_present_in)
         begin
            reset_pend_ff <= 1'b0;
            fault_clear_out <= 1'b1;
         end
         else if (act.fault_reset && !act_q_ff.fault_reset)
         begin
            reset_pend_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sequencer start
   // ----------------------------------------
   logic shot_ff;
   logic seq_run;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shot_ff <= 1'b0;
      end
      else if (act.seq_shot && !act_q_ff.seq_shot)
      begin
         shot_ff <= 1'b1;
      end
      else if (stop_req || act.forced_stop)
      begin
         shot_ff <= 1'b0;
      end
   end

   assign seq_run = (act.seq_level | shot_ff) & (seq_mode_out != mdifd_pkg::SEQ_OFF);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         step_sequencer_run_out <= 1'b0;
         step_sequencer_start_out <= 1'b0;
      end
      else
      begin
         step_sequencer_run_out <= seq_run;
         step_sequencer_start_out <= seq_run & ~step_sequencer_run_out;
      end
   end

   // ----------------------------------------
   // Level functions
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         param_lock_out <= 1'b0;
         loop_regulator_off_out <= 1'b0;
         jog_rev_out <= 1'b0;
         freq_src2_out <= 1'b0;
         op_src2_out <= 1'b0;
         analog_sel_out <= mdifd_pkg::ASEL_VOLT;
         term_level_out <= '0;
      end
      else
      begin
         param_lock_out <= act.param_lock;
         loop_regulator_off_out <= act.loop_off;
         if (jog_active_in)
         begin
            jog_rev_out <= act.jog_dir;
         end
         freq_src2_out <= act.fsrc2;
         op_src2_out <= act.opsrc2;
         if (act.asel_cur && act.asel_bip)
         begin
            analog_sel_out <= mdifd_pkg::ASEL_VOLT;
         end
         else if (act.asel_cur)
         begin
            analog_sel_out <= mdifd_pkg::ASEL_CUR;
         end
         else if (act.asel_bip)
         begin
            analog_sel_out <= mdifd_pkg::ASEL_BIP;
         end
         else
         begin
            analog_sel_out <= mdifd_pkg::ASEL_VOLT;
         end
         term_level_out <= stable_ff;
      end
   end
endmodule // mdifd_decoder

/* core/mdifd_pkg.sv */
package mdifd_pkg;
   // ----------------------------------------
   // Terminal counts and widths
   // ----------------------------------------
   localparam int N_TERM = 6;
   localparam int FUNC_W = 6;
   localparam int FREQ_W = 16;
   localparam int PADDR_W = 5;
   localparam int N_STEP = 15;

   // ----------------------------------------
   // Debounce timing
   // ----------------------------------------
   localparam int CLK_KHZ = 200000;
   localparam int DEB_UNIT_MS = 2;
   localparam int DEB_UNIT_CYC = DEB_UNIT_MS * CLK_KHZ;
   localparam logic [4:0] DEB_MIN = 5'h01;
   localparam logic [4:0] DEB_MAX = 5'h14;
   localparam logic [4:0] DEB_RST = 5'h01;

   // ----------------------------------------
   // Terminal function codes
   // ----------------------------------------
   localparam logic [5:0] F_STEP1 = 6'h01;
   localparam logic [5:0] F_STEP2 = 6'h02;
   localparam logic [5:0] F_STEP3 = 6'h03;
   localparam logic [5:0] F_STEP4 = 6'h04;
   localparam logic [5:0] F_RST_NO = 6'h05;
   localparam logic [5:0] F_SEQ_RUN = 6'h0e;
   localparam logic [5:0] F_ASEL_CUR = 6'h15;
   localparam logic [5:0] F_ASEL_BIP = 6'h16;
   localparam logic [5:0] F_FSTOP_NC = 6'h19;
   localparam logic [5:0] F_FSTOP_NO = 6'h1a;
   localparam logic [5:0] F_PLOCK = 6'h1b;
   localparam logic [5:0] F_LOOP_OFF = 6'h1c;
   localparam logic [5:0] F_JOG_DIR = 6'h1d;
   localparam logic [5:0] F_RST_NC = 6'h1e;
   localparam logic [5:0] F_FSRC2 = 6'h1f;
   localparam logic [5:0] F_OPSRC2 = 6'h20;
   localparam logic [5:0] F_SEQ_SHOT = 6'h21;
   localparam logic [5:0] F_PROX = 6'h22;
   localparam logic [5:0] F_SHUT_NO = 6'h23;
   localparam logic [5:0] F_SHUT_NC = 6'h24;

   // ----------------------------------------
   // Parameter addresses, limits, resets
   // ----------------------------------------
   localparam logic [4:0] PA_STEP_LAST = 5'h0e;
   localparam logic [4:0] PA_GEAR = 5'h0f;
   localparam logic [4:0] PA_ANGLE = 5'h10;
   localparam logic [4:0] PA_DECEL = 5'h11;
   localparam logic [4:0] PA_SEQ_MODE = 5'h12;
   localparam logic [4:0] PA_DEB = 5'h13;
   localparam logic [15:0] STEP_MAX = 16'h9c40;
   localparam logic [15:0] GEAR_MIN = 16'h0004;
   localparam logic [15:0] GEAR_MAX = 16'h03e8;
   localparam logic [15:0] GEAR_RST = 16'h00c8;
   localparam logic [15:0] ANGLE_MAX = 16'h0e10;
   localparam logic [15:0] ANGLE_RST = 16'h0708;
   localparam logic [15:0] DECEL_MAX = 16'h2710;
   localparam logic [15:0] DECEL_RST = 16'h0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SEQ_OFF = 2'b00,
      SEQ_ONCE = 2'b01,
      SEQ_LOOP = 2'b10
   } mdifd_seq_mode_t;

   typedef enum logic [1:0] {
      ASEL_VOLT = 2'b00,
      ASEL_CUR = 2'b01,
      ASEL_BIP = 2'b10
   } mdifd_asel_t;

   typedef enum logic [1:0] {
      ST_STOPPED = 2'b00,
      ST_RUNNING = 2'b01,
      ST_INDEX_WAIT = 2'b10
   } mdifd_run_st_t;

   typedef struct packed {
      logic [15:0] gear;
      logic [15:0] angle;
      logic [15:0] decel;
   } mdifd_index_cfg_t;

   typedef struct packed {
      logic forced_stop;
      logic param_lock;
      logic loop_off;
      logic jog_dir;
      logic fault_reset;
      logic fsrc2;
      logic opsrc2;
      logic seq_level;
      logic seq_shot;
      logic prox;
      logic shutoff;
      logic asel_cur;
      logic asel_bip;
      logic [3:0] step_idx;
   } mdifd_act_t;
endpackage

/* core/mdifd_step_mem.sv */
`timescale 1ns/1ps
module mdifd_step_mem #(
   parameter int DEPTH = 15,
   parameter int WIDTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_ff [DEPTH];

   // Every stored step starts at zero frequency
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_ff[i] <= '0;
         end
      end
      else if (wr_en_in && (int'(wr_addr_in) < DEPTH))
      begin
         mem_ff[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out <= '0;
      end
      else if (int'(rd_addr_in) < DEPTH)
      begin
         rd_data_out <= mem_ff[rd_addr_in];
      end
      else
      begin
         rd_data_out <= '0;
      end
   end
endmodule // mdifd_step_mem

/* tb/mdifd_decoder_monitor.sv */
`timescale 1ns/1ps
module mdifd_decoder_monitor (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic param_wr_in,
   input wire logic [4:0] param_addr_in,
   input wire logic param_ack_out,
   input wire logic param_err_out,
   input wire logic param_lock_out,
   input wire logic jog_active_in,
   input wire logic jog_rev_out,
   input wire logic output_off_out,
   input wire logic restart_zero_out,
   input wire logic run_out,
   input wire logic stop_pulse_out,
   input wire logic index_wait_out,
   input wire logic index_decel_out,
   input wire logic step_sequencer_run_out,
   input wire mdifd_pkg::mdifd_seq_mode_t seq_mode_out,
   input wire logic fault_present_in,
   input wire logic fault_clear_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Lock output lags the decoded level, so it must hold on both edges
   sequence s_locked_wr;
      (param_wr_in && param_lock_out) ##1 param_lock_out;
   endsequence
   AST_LOCK_REFUSE: assert property (s_locked_wr |-> param_err_out && !param_ack_out)
      else $error("write accepted while locked");
   AST_BAD_ADDR: assert property (param_wr_in && param_addr_in > 5'h13 |=> param_err_out)
      else $error("unmapped write not refused");
   AST_NO_ANSWER: assert property (!param_wr_in |=> !param_ack_out && !param_err_out)
      else $error("answer without a write");
   AST_JOG_HOLD: assert property (!$past(jog_active_in) |-> $stable(jog_rev_out))
      else $error("jog direction moved outside jog");
   AST_RESTART: assert property (restart_zero_out |-> !output_off_out)
      else $error("restart while output shut off");
   AST_STOP_CAUSE: assert property ($fell(run_out) |-> stop_pulse_out || index_decel_out
      || $past(stop_pulse_out) || $past(index_decel_out))
      else $error("run dropped without a stop");
   AST_INDEX_DECEL: assert property (index_decel_out |-> index_wait_out
      || $past(index_wait_out))
      else $error("index decel without waiting");
   AST_SEQ_MODE: assert property (step_sequencer_run_out
      |-> $past(seq_mode_out) != mdifd_pkg::SEQ_OFF)
      else $error("sequencer runs while disabled");
   AST_FAULT_CLEAR: assert property (fault_clear_out |-> !$past(fault_present_in))
      else $error("fault cleared while present");
endmodule // mdifd_decoder_monitor
bind mdifd_decoder mdifd_decoder_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .param_wr_in(param_wr_in), .param_addr_in(param_addr_in), .param_ack_out(param_ack_out),
   .param_err_out(param_err_out), .param_lock_out(param_lock_out),
   .jog_active_in(jog_active_in), .jog_rev_out(jog_rev_out), .output_off_out(output_off_out),
   .restart_zero_out(restart_zero_out), .run_out(run_out), .stop_pulse_out(stop_pulse_out),
   .index_wait_out(index_wait_out), .index_decel_out(index_decel_out),
   .step_sequencer_run_out(step_sequencer_run_out), .seq_mode_out(seq_mode_out),
   .fault_present_in(fault_present_in), .fault_clear_out(fault_clear_out));

/* tb/mdifd_decoder_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module mdifd_decoder_tb;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [5:0] want = 6'h00;
   logic [5:0] contact;
   logic [5:0][5:0] func = {mdifd_pkg::F_JOG_DIR, mdifd_pkg::F_PLOCK, mdifd_pkg::F_STEP4,
      mdifd_pkg::F_STEP3, mdifd_pkg::F_STEP2, mdifd_pkg::F_STEP1};
   logic jog = 1'b0;
   logic run1 = 1'b0;
   logic stop1 = 1'b0;
   logic seq;
   logic wr = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] data = 16'h0000;
   logic err, lock, run, jrev;
   logic [3:0] idx;
   logic [15:0] freq;
   mdifd_pkg::mdifd_seq_mode_t mode;
   mdifd_pkg::mdifd_index_cfg_t cfg;
   int num_errors = 0;
   int n_tests = 0;
   mdifd_switch_model u_sw (.want_in(want), .contact_out(contact));
   mdifd_decoder #(.DEB_UNIT_CYC(4)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .term_contact_in(contact), .term_func_in(func), .jog_active_in(jog), .run1_in(run1),
      .stop1_in(stop1), .run2_in(1'b0), .stop2_in(1'b0), .fault_present_in(1'b0),
      .master_freq_in(16'h1234), .param_wr_in(wr), .param_addr_in(addr),
      .param_data_in(data), .param_ack_out(), .param_err_out(err), .param_lock_out(lock),
      .run_out(run), .stop_pulse_out(), .index_wait_out(), .index_decel_out(),
      .output_off_out(), .restart_zero_out(), .fault_clear_out(),
      .loop_regulator_off_out(), .jog_rev_out(jrev), .freq_src2_out(), .op_src2_out(),
      .analog_sel_out(), .step_idx_out(idx), .step_freq_out(freq),
      .step_sequencer_run_out(seq), .step_sequencer_start_out(), .seq_mode_out(mode),
      .index_cfg_out(cfg), .term_level_out());
   initial forever #2.5 clk_in = ~clk_in;
   task automatic wr_par(input logic [4:0] a, input logic [15:0] d, input logic e_err);
      @(negedge clk_in);
      wr = 1'b1;
      addr = a;
      data = d;
      @(negedge clk_in);
      `CHK("err", e_err, err)
      wr = 1'b0;
   endtask
   // Long enough for sync, one filter unit and the output register
   task automatic put(input logic [5:0] w);
      want = w;
      repeat (40) @(negedge clk_in);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      end_of_test();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      `CHK("cfg", {mdifd_pkg::GEAR_RST, mdifd_pkg::ANGLE_RST, 16'h0000}, cfg)
      wr_par(5'h00, mdifd_pkg::STEP_MAX, 1'b0);
      wr_par(5'h01, mdifd_pkg::STEP_MAX + 16'h0001, 1'b1);
      wr_par(mdifd_pkg::PA_GEAR, 16'h0003, 1'b1);
      wr_par(mdifd_pkg::PA_GEAR, mdifd_pkg::GEAR_MAX, 1'b0);
      `CHK("gear", mdifd_pkg::GEAR_MAX, cfg.gear)
      wr_par(5'h14, 16'h0000, 1'b1);
      wr_par(mdifd_pkg::PA_SEQ_MODE, 16'h0003, 1'b1);
      for (int m = 2; m >= 0; m--)
      begin
         wr_par(mdifd_pkg::PA_SEQ_MODE, 16'(m), 1'b0);
         `CHK("mode", 2'(m), mode)
      end
      $display("parameter test done");
      for (int i = 0; i < 4; i++)
      begin
         put(6'(1 << i));
         `CHK("idx", 4'(1 << i), idx)
      end
      put(6'h01);
      `CHK("freq", mdifd_pkg::STEP_MAX, freq)
      put(6'h00);
      `CHK("freq", 16'h1234, freq)
      $display("step test done");
      put(6'h10);
      `CHK("lock", 1'b1, lock)
      wr_par(5'h00, 16'h0005, 1'b1);
      put(6'h01);
      `CHK("freq", mdifd_pkg::STEP_MAX, freq)
      $display("lock test done");
      put(6'h20);
      `CHK("jog", 1'b0, jrev)
      jog = 1'b1;
      put(6'h20);
      `CHK("jog", 1'b1, jrev)
      jog = 1'b0;
      put(6'h00);
      `CHK("jog", 1'b1, jrev)
      $display("jog test done");
      func[5] = mdifd_pkg::F_FSTOP_NO;
      run1 = 1'b1;
      @(negedge clk_in);
      run1 = 1'b0;
      put(6'h00);
      `CHK("run", 1'b1, run)
      put(6'h20);
      `CHK("run", 1'b0, run)
      put(6'h00);
      `CHK("run", 1'b0, run)
      run1 = 1'b1;
      @(negedge clk_in);
      run1 = 1'b0;
      put(6'h00);
      `CHK("run", 1'b1, run)
      stop1 = 1'b1;
      @(negedge clk_in);
      stop1 = 1'b0;
      put(6'h00);
      `CHK("run", 1'b0, run)
      $display("stop test done");
      func[5] = mdifd_pkg::F_SEQ_RUN;
      wr_par(mdifd_pkg::PA_SEQ_MODE, 16'h0001, 1'b0);
      put(6'h20);
      `CHK("seq", 1'b1, seq)
      put(6'h00);
      `CHK("seq", 1'b0, seq)
      $display("seq test done");
      end_of_test();
   end
endmodule // mdifd_decoder_tb

/* tb/mdifd_switch_model.sv */
`timescale 1ns/1ps
// Field contacts: each change chatters briefly before it settles
module mdifd_switch_model (
   input wire logic [5:0] want_in,
   output logic [5:0] contact_out
);
   logic [5:0] last_ff = 6'h00;
   initial contact_out = 6'h00;
   // Bounce is kept far shorter than one filter unit so it must vanish
   always @(want_in)
   begin
      contact_out = want_in;
      #3 contact_out = last_ff;
      #4 contact_out = want_in;
      last_ff = want_in;
   end
endmodule // mdifd_switch_model
